/* fwg_pkg.sv */
// constants and types shared by the flash write guard host controller
package fwg_pkg;
	localparam int CLK_NS       = 4;
	// write pulses must outlast the device glitch filter
	localparam int GLITCH_NS    = 5;
	localparam int GLITCH_CYC   = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWRUP_NS     = 1000;
	localparam int PWRUP_CYC    = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HWRST_NS     = 500;
	localparam int HWRST_CYC    = (HWRST_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_NS     = 200;
	localparam int RECOV_CYC    = (RECOV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 12;

	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_FADDR  = 8'h04;
	localparam logic [7:0] ADDR_WDATA  = 8'h08;
	localparam logic [7:0] ADDR_CMD    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	localparam int CTRL_WP_BIT  = 0;
	localparam int CTRL_TOP_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_SEC_BIT    = 1;
	localparam int ST_LOCKED_BIT = 2;
	localparam int ST_ERR_BIT    = 3;
	localparam int ST_BOOT_BIT   = 4;
	localparam int ST_SER_BIT    = 5;
	localparam int ST_RDATA_LSB  = 16;

	// group address with only A1, A3 and A4 high
	localparam logic [19:0] SEC_GROUP_ADDR  = 20'h0001A;
	localparam logic [19:0] SERIAL_BOT_ADDR = 20'h00000;
	localparam logic [19:0] SERIAL_TOP_ADDR = 20'hFFFF0;
	localparam logic [19:0] SERIAL_LEN      = 20'h00010;
	// two outermost 8K-word sectors span 16K words: address bits 19..14
	localparam int BOOT_LSB = 14;

	typedef enum logic [2:0] {
		OP_READ    = 3'b000,
		OP_WRITE   = 3'b001,
		OP_PROGRAM = 3'b010,
		OP_ENTER   = 3'b011,
		OP_EXIT    = 3'b100,
		OP_LOCK    = 3'b101,
		OP_HWRESET = 3'b110
	} fwg_op_type;

	typedef enum logic [1:0] {
		MS_PWRUP = 2'b00,
		MS_IDLE  = 2'b01,
		MS_RUN   = 2'b10,
		MS_HWRST = 2'b11
	} fwg_main_type;

	typedef enum logic [1:0] {
		CS_IDLE  = 2'b00,
		CS_SETUP = 2'b01,
		CS_ACT   = 2'b10,
		CS_HOLD  = 2'b11
	} fwg_cyc_type;
endpackage

/* fwg_bus_cycle.sv */
// one asynchronous flash bus cycle, read or write, with registered pins
`timescale 1ns/1ps
module fwg_bus_cycle #(
	parameter int ACT_CYC = 8
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic        write_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] data_i,
	input  wire logic [15:0] dq_i,
	output logic             ce_n_o,
	output logic             oe_n_o,
	output logic             we_n_o,
	output logic [19:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic             dq_oe_o,
	output logic [15:0]      rdata_o,
	output logic             done_o
);
	import fwg_pkg::*;

	// pulse never shorter than the glitch filter
	localparam int PULSE = (ACT_CYC > GLITCH_CYC) ? ACT_CYC : GLITCH_CYC + 1;

	fwg_cyc_type state_q;
	logic [7:0]  cnt_q;
	logic        wr_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= CS_IDLE;
			cnt_q   <= 8'h00;
			wr_q    <= 1'b0;
			ce_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			dq_oe_o <= 1'b0;
			done_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				CS_IDLE: begin
					if (start_i) begin
						wr_q    <= write_i;
						ce_n_o  <= 1'b0;
						dq_oe_o <= write_i;
						state_q <= CS_SETUP;
					end
				end
				CS_SETUP: begin
					// oe stays high for the whole write
					we_n_o  <= ~wr_q;
					oe_n_o  <= wr_q;
					cnt_q   <= 8'(PULSE - 1);
					state_q <= CS_ACT;
				end
				CS_ACT: begin
					if (cnt_q == 8'h00) begin
						we_n_o  <= 1'b1;
						oe_n_o  <= 1'b1;
						state_q <= CS_HOLD;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				CS_HOLD: begin
					ce_n_o  <= 1'b1;
					dq_oe_o <= 1'b0;
					done_o  <= 1'b1;
					state_q <= CS_IDLE;
				end
				default: state_q <= CS_IDLE;
			endcase
		end
	end

	// address and data held steady through the whole cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_o <= 20'h00000;
			dq_o   <= 16'h0000;
		end else if (state_q == CS_IDLE && start_i) begin
			addr_o <= addr_i;
			dq_o   <= data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (state_q == CS_ACT && cnt_q == 8'h00 && !wr_q) begin
			rdata_o <= dq_i;
		end
	end
endmodule

/* fwg_host.sv */
// host controller driving a parallel flash with guarded sequences
// Overview of operation
// - unlock cycles precede every program command
// - write cycle: ce and we low, oe high
// - lock: enter, then group protect address
// - exit secured mode before main array use
`timescale 1ns/1ps
module fwg_host #(
	parameter int          ACT_CYC     = 8,
	parameter logic [19:0] SEQ_ADDR1   = 20'h00001,
	parameter logic [15:0] SEQ_DATA1   = 16'h0001,
	parameter logic [19:0] SEQ_ADDR2   = 20'h00002,
	parameter logic [15:0] SEQ_DATA2   = 16'h0002,
	parameter logic [15:0] CMD_PROGRAM = 16'h0003,
	parameter logic [15:0] CMD_ENTER   = 16'h0004,
	parameter logic [15:0] CMD_EXIT    = 16'h0005,
	parameter logic [15:0] CMD_EXIT2   = 16'h0000,
	parameter logic [15:0] CMD_PROTECT = 16'h0006
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic [19:0]      fl_addr_o,
	output logic [15:0]      fl_dq_o,
	output logic             fl_dq_oe_o,
	input  wire logic [15:0] fl_dq_i,
	output logic             fl_ce_n_o,
	output logic             fl_oe_n_o,
	output logic             fl_we_n_o,
	output logic             fl_wp_n_o,
	output logic             fl_reset_n_o
);
	import fwg_pkg::*;

	logic [1:0]       ctrl_q;
	logic [19:0]      faddr_q;
	logic [15:0]      wdata_q;
	logic [15:0]      rdata_q;
	logic             err_q;
	logic             secured_q;
	logic             lock_pend_q;
	fwg_main_type     mst_q;
	fwg_op_type       op_q;
	logic [1:0]       step_q;
	logic [1:0]       last_q;
	logic [CNT_W-1:0] cnt_q;
	logic             start_q;
	logic             cyc_done;
	logic [15:0]      cyc_rdata;
	logic [19:0]      st_addr;
	logic [15:0]      st_data;
	logic             st_we;
	logic             wb_hit;
	logic             cmd_go;
	logic             refuse;
	logic             boot_hit;
	logic             ser_hit;
	fwg_op_type       new_op;

	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign cmd_go = wb_hit & wb_we_i & (wb_adr_i == ADDR_CMD) & wb_sel_i[0];
	assign new_op = fwg_op_type'(wb_dat_i[2:0]);

	// lock only from secured mode; after a lock only exit or reset
	assign refuse = (mst_q != MS_IDLE)
		| (new_op == OP_LOCK && !secured_q)
		| (lock_pend_q && new_op != OP_EXIT
			&& new_op != OP_HWRESET)
		| (new_op == 3'b111);

	// host-side view of the two outermost boot sectors
	assign boot_hit = ctrl_q[CTRL_TOP_BIT]
		? (&faddr_q[19:BOOT_LSB])
		: (~|faddr_q[19:BOOT_LSB]);
	assign ser_hit = ctrl_q[CTRL_TOP_BIT]
		? (faddr_q >= SERIAL_TOP_ADDR)
		: (faddr_q < SERIAL_BOT_ADDR + SERIAL_LEN);

	// step table: full sequences only, never the bypass shortcut
	always_comb begin
		st_addr = faddr_q;
		st_data = wdata_q;
		st_we   = 1'b1;
		case (op_q)
			OP_READ: st_we = 1'b0;
			OP_PROGRAM, OP_ENTER, OP_EXIT: begin
				case (step_q)
					2'd0: begin
						st_addr = SEQ_ADDR1;
						st_data = SEQ_DATA1;
					end
					2'd1: begin
						st_addr = SEQ_ADDR2;
						st_data = SEQ_DATA2;
					end
					2'd2: begin
						st_addr = SEQ_ADDR1;
						st_data = (op_q == OP_PROGRAM) ? CMD_PROGRAM
							: (op_q == OP_ENTER) ? CMD_ENTER : CMD_EXIT;
					end
					default: begin
						if (op_q == OP_EXIT) begin
							st_data = CMD_EXIT2;
						end
					end
				endcase
			end
			OP_LOCK: begin
				st_addr = SEC_GROUP_ADDR;
				st_data = CMD_PROTECT;
			end
			default: st_we = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mst_q        <= MS_PWRUP;
			cnt_q        <= CNT_W'(PWRUP_CYC);
			op_q         <= OP_READ;
			step_q       <= 2'd0;
			last_q       <= 2'd0;
			start_q      <= 1'b0;
			fl_reset_n_o <= 1'b1;
		end else begin
			start_q <= 1'b0;
			case (mst_q)
				MS_PWRUP: begin
					// no strobes until the device has settled
					if (cnt_q == '0) begin
						mst_q <= MS_IDLE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				MS_IDLE: begin
					if (cmd_go && !refuse) begin
						op_q   <= new_op;
						step_q <= 2'd0;
						if (new_op == OP_HWRESET) begin
							fl_reset_n_o <= 1'b0;
							cnt_q        <= CNT_W'(HWRST_CYC - 1);
							mst_q        <= MS_HWRST;
						end else begin
							last_q  <= (new_op == OP_PROGRAM
								|| new_op == OP_EXIT) ? 2'd3
								: (new_op == OP_ENTER) ? 2'd2 : 2'd0;
							start_q <= 1'b1;
							mst_q   <= MS_RUN;
						end
					end
				end
				MS_RUN: begin
					if (cyc_done) begin
						if (step_q == last_q) begin
							mst_q <= MS_IDLE;
						end else begin
							step_q  <= step_q + 2'd1;
							start_q <= 1'b1;
						end
					end
				end
				MS_HWRST: begin
					if (cnt_q == '0) begin
						fl_reset_n_o <= 1'b1;
						cnt_q        <= CNT_W'(RECOV_CYC);
						mst_q        <= MS_PWRUP;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: mst_q <= MS_IDLE;
			endcase
		end
	end

	// overlay tracking follows the device: reset ends it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			secured_q   <= 1'b0;
			lock_pend_q <= 1'b0;
		end else if (mst_q == MS_HWRST) begin
			secured_q   <= 1'b0;
			lock_pend_q <= 1'b0;
		end else if (mst_q == MS_RUN && cyc_done && step_q == last_q) begin
			case (op_q)
				OP_ENTER: secured_q <= 1'b1;
				OP_EXIT: begin
					secured_q   <= 1'b0;
					lock_pend_q <= 1'b0;
				end
				OP_LOCK: lock_pend_q <= 1'b1;
				default: secured_q <= secured_q;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
		end else if (mst_q == MS_RUN && cyc_done && op_q == OP_READ) begin
			rdata_q <= cyc_rdata;
		end
	end

	// a refusal in the clearing cycle still sets the flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_q <= 1'b0;
		end else if (cmd_go && refuse) begin
			err_q <= 1'b1;
		end else if (wb_hit && wb_we_i && wb_adr_i == ADDR_STATUS
			&& wb_sel_i[0] && wb_dat_i[ST_ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q  <= CTRL_RESET;
			faddr_q <= 20'h00000;
			wdata_q <= 16'h0000;
		end else if (wb_hit && wb_we_i) begin
			case (wb_adr_i)
				ADDR_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl_q <= wb_dat_i[1:0];
					end
				end
				ADDR_FADDR: begin
					if (wb_sel_i[0]) faddr_q[7:0]   <= wb_dat_i[7:0];
					if (wb_sel_i[1]) faddr_q[15:8]  <= wb_dat_i[15:8];
					if (wb_sel_i[2]) faddr_q[19:16] <= wb_dat_i[19:16];
				end
				ADDR_WDATA: begin
					if (wb_sel_i[0]) wdata_q[7:0]  <= wb_dat_i[7:0];
					if (wb_sel_i[1]) wdata_q[15:8] <= wb_dat_i[15:8];
				end
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// protect pin straight from the control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_wp_n_o <= CTRL_RESET[CTRL_WP_BIT];
		end else begin
			fl_wp_n_o <= ctrl_q[CTRL_WP_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= 32'h00000000;
			if (wb_hit && !wb_we_i) begin
				case (wb_adr_i)
					ADDR_CTRL:  wb_dat_o <= {30'h0, ctrl_q};
					ADDR_FADDR: wb_dat_o <= {12'h000, faddr_q};
					ADDR_WDATA: wb_dat_o <= {16'h0000, wdata_q};
					ADDR_STATUS: begin
						wb_dat_o[ST_BUSY_BIT]   <= mst_q != MS_IDLE;
						wb_dat_o[ST_SEC_BIT]    <= secured_q;
						wb_dat_o[ST_LOCKED_BIT] <= lock_pend_q;
						wb_dat_o[ST_ERR_BIT]    <= err_q;
						wb_dat_o[ST_BOOT_BIT]   <= boot_hit;
						wb_dat_o[ST_SER_BIT]    <= ser_hit;
						wb_dat_o[31:ST_RDATA_LSB] <= rdata_q;
					end
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	fwg_bus_cycle #(
		.ACT_CYC (ACT_CYC)
	) u_cycle (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (start_q),
		.write_i (st_we),
		.addr_i  (st_addr),
		.data_i  (st_data),
		.dq_i    (fl_dq_i),
		.ce_n_o  (fl_ce_n_o),
		.oe_n_o  (fl_oe_n_o),
		.we_n_o  (fl_we_n_o),
		.addr_o  (fl_addr_o),
		.dq_o    (fl_dq_o),
		.dq_oe_o (fl_dq_oe_o),
		.rdata_o (cyc_rdata),
		.done_o  (cyc_done)
	);
endmodule

/* fwg_flash_model.sv */
// behavioural flash part answering the host controller
`timescale 1ns/1ps
module fwg_flash_model #(
	parameter bit LOCK_IND = 1'h0 // lock indicator, fixed
) (
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        wp_n_i,
	input  wire logic        reset_n_i
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] sec [logic [7:0]];
	logic [15:0] last = 16'h0000;
	int          step = 0;
	bit          in_sec = 1'h0;
	bit          prog = 1'h0;
	bit          locked = LOCK_IND; // factory part starts unlocked
	realtime     t0;
	wire         wp_lo = wp_n_i === 1'h0; // open pin reads high
	// pin guard holds for main array writes only; secured overlay writes ignore it
	wire         boot = addr_i[19:14] == 6'h00; // bottom pair
	wire         ovl = in_sec && addr_i[19:8] == 12'h000;

	task automatic wcyc;
		if (prog) begin
			prog = 1'h0;
			if (ovl && !locked) // a locked region never changes
				sec[addr_i[7:0]] = dq_i;
			else if (!ovl && !(boot && wp_lo))
				mem[addr_i] = dq_i;
		end else if (step == 0 && addr_i == 20'h00001 && dq_i == 16'h0001)
			step = 1;
		else if (step == 1 && addr_i == 20'h00002 && dq_i == 16'h0002)
			step = 2;
		else if (step == 2 && addr_i == 20'h00001) begin // full unlock
			prog = dq_i == 16'h0003;
			in_sec = dq_i == 16'h0004 || (in_sec && dq_i != 16'h0005);
			step = 0;
		end else begin
			locked = locked || (in_sec && addr_i == 20'h0001A && dq_i == 16'h0006);
			step = 0;
		end
	endtask

	always @(negedge reset_n_i) begin
		in_sec = 1'h0;
		prog = 1'h0;
		step = 0;
	end
	always @(negedge we_n_i) t0 = $realtime;
	// strobes under 5 ns and inhibit combinations are dropped
	// writes while reset is held are ignored, as under supply lockout
	always @(posedge we_n_i)
		if (!ce_n_i && oe_n_i && reset_n_i && $realtime - t0 >= 5.0)
			wcyc();
	always @(ce_n_i, oe_n_i, addr_i, in_sec)
		if (!ce_n_i && !oe_n_i) begin
			if (ovl)
				dq_o = sec.exists(addr_i[7:0]) ? sec[addr_i[7:0]] : 16'hFFFF;
			else
				dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
			last = dq_o;
		end else
			dq_o = ~last; // released bus shows no stale data
endmodule

/* fwg_host_sva.sv */
// assertions on the flash host pins and bus handshake
`timescale 1ns/1ps
module fwg_host_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [19:0] fl_addr_o,
	input wire logic fl_dq_oe_o,
	input wire logic fl_ce_n_o,
	input wire logic fl_oe_n_o,
	input wire logic fl_we_n_o,
	input wire logic fl_reset_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_write_oe_high: assert property (
		!fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o) else $error("bad write strobe");
	a_we_no_glitch: assert property (
		$fell(fl_we_n_o) |-> !fl_we_n_o [*3]) else $error("short we pulse");
	a_oe_no_glitch: assert property (
		$fell(fl_oe_n_o) |-> !fl_oe_n_o [*3]) else $error("short oe pulse");
	a_ce_leads_we: assert property (
		$fell(fl_we_n_o) |-> $past(!fl_ce_n_o)) else $error("we before ce");
	a_write_drives_dq: assert property (
		!fl_we_n_o |-> fl_dq_oe_o) else $error("write without data drive");
	a_read_floats_dq: assert property (
		!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o) else $error("read with drive");
	a_addr_held: assert property (
		!fl_ce_n_o && $past(!fl_ce_n_o) |-> $stable(fl_addr_o))
		else $error("address moved in cycle");
	a_ack_pulse: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");
	a_reset_pulse: assert property (
		$fell(fl_reset_n_o) |-> !fl_reset_n_o [*8]) else $error("short reset");
	cover property ($fell(fl_we_n_o));
	cover property ($fell(fl_oe_n_o));
	cover property ($fell(fl_reset_n_o));
endmodule

bind fwg_host fwg_host_sva u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_dq_oe_o(fl_dq_oe_o),
	.fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
	.fl_reset_n_o(fl_reset_n_o)
);

/* tb_top.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_top;
	import fwg_pkg::*;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat, wb_dat_o;
	logic [3:0]  wb_sel;
	logic        wb_ack_o, ce_n, oe_n, we_n, wp_n, rst_n, dq_oe;
	logic [19:0] faddr, a;
	logic [15:0] dq_h, dq_m, d;
	wire  [15:0] dq_w = dq_oe ? dq_h : dq_m;
	logic [31:0] exp_q[$], msk_q[$], e, m;
	int          error_cnt, checked, seed;

	fwg_host u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fl_addr_o(faddr), .fl_dq_o(dq_h), .fl_dq_oe_o(dq_oe),
		.fl_dq_i(dq_w), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
		.fl_we_n_o(we_n), .fl_wp_n_o(wp_n), .fl_reset_n_o(rst_n)
	);
	fwg_flash_model u_mem (
		.addr_i(faddr), .dq_i(dq_w), .dq_o(dq_m), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .we_n_i(we_n), .wp_n_i(wp_n), .reset_n_i(rst_n)
	);

	task automatic finish_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic hang;
		error_cnt++;
		$display("unexpected wait timeout");
		finish_test();
	endtask
	task automatic wb(input logic [7:0] ad, input logic w,
			input logic [31:0] dt, output logic [31:0] q);
		int n = 0;
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_adr <= ad;
		wb_we  <= w;
		wb_dat <= dt;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		if (wb_ack_o !== 1'h1)
			hang();
		q = wb_dat_o;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		logic [31:0] q;
		wb(ad, 1'h1, dt, q);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex, mk);
		logic [31:0] q;
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		wb(ad, 1'h0, 32'h0, q);
	endtask
	task automatic poll;
		logic [31:0] q = 32'h1;
		int n = 0;
		while (q[0] !== 1'h0 && n < 400) begin
			exp_q.push_back(32'h0);
			msk_q.push_back(32'h0);
			wb(ADDR_STATUS, 1'h0, 32'h0, q);
			n++;
		end
		if (q[0] !== 1'h0)
			hang();
	endtask
	task automatic op(input logic [2:0] c);
		wr(ADDR_CMD, {29'h0, c});
		poll();
	endtask
	task automatic prog(input logic [19:0] ad, input logic [15:0] dt);
		wr(ADDR_FADDR, {12'h0, ad});
		wr(ADDR_WDATA, {16'h0, dt});
		op(OP_PROGRAM);
	endtask
	task automatic rdf(input logic [19:0] ad, input logic [15:0] ex);
		wr(ADDR_FADDR, {12'h0, ad});
		op(OP_READ);
		rd(ADDR_STATUS, {ex, 16'h0}, 32'hFFFF0000);
	endtask
	task automatic cmp(input logic [31:0] ex, input logic [31:0] sn);
		checked++;
		if (sn !== ex) begin
			error_cnt++;
			$display("unexpected wb_dat_o exp %h got %h", ex, sn);
		end
	endtask

	// oldest note is matched to each read answer as it appears
	always @(posedge clk_i)
		if (wb_ack_o === 1'h1 && wb_we === 1'h0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			if (m != 32'h0)
				cmp(e & m, wb_dat_o & m);
		end

	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		{error_cnt, checked, seed} = {32'h0, 32'h0, 32'h17};
		{rst_i, wb_cyc, wb_stb, wb_we} = 4'h8;
		{wb_adr, wb_dat, wb_sel} = {8'h0, 32'h0, 4'hF};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rd(ADDR_CTRL, 32'h1, 32'h3);
		rd(8'h14, 32'h0, 32'hFFFFFFFF);
		wr(ADDR_CMD, {29'h0, OP_READ}); // refused while power-up busy
		rd(ADDR_STATUS, 32'h9, 32'h9);
		poll();
		wr(ADDR_STATUS, 32'h8);
		repeat (4) begin
			a = 20'h40000 | 20'($random(seed)) & 20'h3FFFE;
			d = 16'($random(seed));
			prog(a, d);
			rdf(a, d);
		end
		wr(ADDR_FADDR, 32'h40001);
		wr(ADDR_WDATA, 32'h5A5A);
		op(OP_WRITE);
		rd(ADDR_STATUS, 32'h0, 32'h9);
		rdf(20'h40001, 16'hFFFF);
		wr(ADDR_CTRL, 32'h0);
		prog(20'h00100, 16'h1234);
		rdf(20'h00100, 16'hFFFF);
		wr(ADDR_CTRL, 32'h1);
		prog(20'h00100, 16'h1234);
		rdf(20'h00100, 16'h1234);
		rd(ADDR_STATUS, 32'h10, 32'h30);
		wr(ADDR_FADDR, 32'h5);
		rd(ADDR_STATUS, 32'h30, 32'h30);
		wr(ADDR_CTRL, 32'h3);
		wr(ADDR_FADDR, 32'hFFFF5);
		rd(ADDR_STATUS, 32'h30, 32'h30);
		wr(ADDR_CTRL, 32'h1);
		op(OP_LOCK);
		rd(ADDR_STATUS, 32'h8, 32'hE);
		wr(ADDR_STATUS, 32'h8);
		op(3'h7);
		rd(ADDR_STATUS, 32'h8, 32'h8);
		wr(ADDR_STATUS, 32'h8);
		op(OP_ENTER);
		rd(ADDR_STATUS, 32'h2, 32'hE);
		prog(20'h00000, 16'hA5A5);
		rdf(20'h00000, 16'hA5A5);
		op(OP_LOCK);
		rd(ADDR_STATUS, 32'h6, 32'hE);
		op(OP_PROGRAM);
		rd(ADDR_STATUS, 32'hE, 32'hE);
		wr(ADDR_STATUS, 32'h8);
		op(OP_EXIT);
		rd(ADDR_STATUS, 32'h0, 32'hE);
		rdf(20'h00000, 16'hFFFF);
		op(OP_ENTER);
		prog(20'h00000, 16'h0F0F);
		rdf(20'h00000, 16'hA5A5);
		op(OP_HWRESET);
		rd(ADDR_STATUS, 32'h0, 32'h2);
		rdf(20'h00000, 16'hFFFF);
		finish_test();
	end
endmodule
